/* rtl/epl_pkg.sv */
// constants, encodings and state type of the ecp parallel port
// assumes one 100 MHz clock domain; pins are synchronised in the top
package epl_pkg;

  // ----------------------------------------------------------------
  // register offsets from the port base
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_DATA = 16'h0000;
  localparam logic [15:0] OFS_STATUS = 16'h0001;
  localparam logic [15:0] OFS_CONTROL = 16'h0002;
  localparam logic [15:0] OFS_FIFO = 16'h0400;
  localparam logic [15:0] OFS_CFGB = 16'h0401;
  localparam logic [15:0] OFS_ECR = 16'h0402;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  // stored extended control bits [7:2] held as a 6-bit field
  localparam int ECR_MODE_LSB = 3;
  localparam int ECR_NERRINT = 2;
  localparam int ECR_DMAEN = 1;
  localparam int ECR_SVC = 0;
  localparam int DCR_STROBE = 0;
  localparam int DCR_AUTOFD = 1;
  localparam int DCR_NINIT = 2;
  localparam int DCR_SELIN = 3;
  localparam int DCR_DIR = 5;
  localparam int RLE_ADDR_BIT = 7;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [5:0] DCR_RESET = 6'h00;
  localparam logic [5:0] ECR_RESET = 6'h05;
  localparam logic [7:0] CFGA_VALUE = 8'h10;
  // pins at rest: pd, nack, busy, perror, select, nfault
  localparam logic [12:0] PIN_IDLE = 13'h0015;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int FIFO_W = 9;

  // ----------------------------------------------------------------
  // modes and link states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_STD = 3'h0,
    MODE_BYTE = 3'h1,
    MODE_COMPAT_FIFO = 3'h2,
    MODE_ECP = 3'h3,
    MODE_EPP = 3'h4,
    MODE_RSVD = 3'h5,
    MODE_TEST = 3'h6,
    MODE_CONFIG = 3'h7
  } epl_mode_e;

  typedef enum logic [2:0] {
    LS_IDLE = 3'h0,
    LS_FWD_SETUP = 3'h1,
    LS_FWD_STROBE = 3'h3,
    LS_FWD_RELEASE = 3'h2,
    LS_REV_REQ = 3'h6,
    LS_REV_DONE = 3'h7,
    LS_REV_EXPAND = 3'h5
  } epl_link_e;

endpackage : epl_pkg

/* rtl/epl_fifo_if.sv */
// push and pop bundle between the port logic and its byte fifo
// assumes the fifo owner and the user share one clock
interface epl_fifo_if #(
  parameter int W = 9,
  parameter int DEPTH = 16
);
  logic push;
  logic pop;
  logic flush;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic full;
  logic empty;
  logic [$clog2(DEPTH+1)-1:0] count;
  modport ctl(output push, pop, flush, wdata, input rdata, full, empty, count);
  modport mem(input push, pop, flush, wdata, output rdata, full, empty, count);
endinterface : epl_fifo_if

/* rtl/epl_sync.sv */
// three stage pin synchroniser with agreement filter
// assumes asynchronous inputs; output moves when stages two and three agree
module epl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("epl_sync width must be at least one");
  end

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      o_sync <= INIT;
    end
    else if (i_ce)
    begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        o_sync <= s3_q;
    end
  end

endmodule : epl_sync

/* rtl/epl_fifo.sv */
// shared byte fifo with a tag bit per entry, flip-flop storage
// assumes the user never pushes on full nor pops on empty with effect
module epl_fifo
  import epl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEF
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  epl_fifo_if.mem bus
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [FIFO_W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  wire do_push = bus.push && (cnt_q != CW'(DEPTH));
  wire do_pop = bus.pop && (cnt_q != '0);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("epl_fifo depth must be a power of two");
  end

  assign bus.rdata = mem_q[rd_q];
  assign bus.full = (cnt_q == CW'(DEPTH));
  assign bus.empty = (cnt_q == '0);
  assign bus.count = cnt_q;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (i_ce)
    begin
      if (bus.flush)
      begin
        wr_q <= '0;
        rd_q <= '0;
        cnt_q <= '0;
      end
      else
      begin
        if (do_push)
          wr_q <= wr_q + AW'(1);
        if (do_pop)
          rd_q <= rd_q + AW'(1);
        cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_ce && do_push && !bus.flush)
      mem_q[wr_q] <= bus.wdata;
  end

  AST_FIFO_BOUND: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    cnt_q <= CW'(DEPTH)) else $error("fifo count beyond depth");

endmodule : epl_fifo

/* rtl/epl_parallel_port.sv */
// ecp capable parallel port: register decode, fifo modes, link engine
// assumes an isa-like strobed register bus and a 1284 peripheral on the pins
module epl_parallel_port
  import epl_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire logic I_CLK_EN,
  input wire logic [15:0] I_BASE_ADDR,
  input wire logic [15:0] I_ADDR,
  input wire logic I_ADDRESS_ENABLE_QUALIFIER,
  input wire logic I_RD_STB,
  input wire logic I_WR_STB,
  input wire logic [7:0] I_WDATA,
  input wire logic I_DMA_ACK,
  input wire logic [5:0] I_CFG_RESOURCES,
  input wire logic [7:0] I_PD_IN,
  input wire logic I_NACK,
  input wire logic I_BUSY,
  input wire logic I_PERROR,
  input wire logic I_SELECT,
  input wire logic I_NFAULT,
  output logic [7:0] O_RDATA,
  output logic O_RDATA_VLD,
  output logic O_DMA_REQ,
  output logic O_FAULT_IRQ,
  output logic [7:0] O_PD_OUT,
  output logic O_PD_OE,
  output logic O_NSTROBE,
  output logic O_NAUTOFD,
  output logic O_NINIT,
  output logic O_NSELECTIN
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [12:0] pins_s;
  wire [7:0] pd_s = pins_s[12:5];
  wire nack_s = pins_s[4];
  wire busy_s = pins_s[3];
  wire perror_s = pins_s[2];
  wire select_s = pins_s[1];
  wire nfault_s = pins_s[0];

  epl_sync #(.WIDTH(13), .INIT(PIN_IDLE)) u_sync (
    .i_clk(I_CLOCK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CLK_EN),
    .i_async({I_PD_IN, I_NACK, I_BUSY, I_PERROR, I_SELECT, I_NFAULT}),
    .o_sync(pins_s)
  );

  // ----------------------------------------------------------------
  // registers and fifo
  // ----------------------------------------------------------------
  logic [7:0] data_q;
  logic [5:0] dcr_q;
  logic [5:0] ecr_q;
  logic [7:0] last_q;
  logic nfault_prev_q;
  epl_link_e st_q;
  epl_link_e st_d;
  logic [7:0] link_data_q;
  logic link_tag_q;
  logic rle_pend_q;
  logic [6:0] rle_cnt_q;
  logic [7:0] rep_q;
  logic [7:0] rep_data_q;

  epl_fifo_if #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) fifo_bus ();

  epl_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLOCK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CLK_EN),
    .bus(fifo_bus)
  );

  wire epl_mode_e mode = epl_mode_e'(ecr_q[ECR_MODE_LSB +: 3]);
  wire dir = dcr_q[DCR_DIR];
  wire is_ecp = (mode == MODE_ECP);
  wire fwd_mode = (mode == MODE_COMPAT_FIFO) || (is_ecp && !dir);
  wire rev_mode = is_ecp && dir;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // base offset, enable qualified
  wire [15:0] ofs = I_ADDR - I_BASE_ADDR;
  wire cpu_cyc = !I_ADDRESS_ENABLE_QUALIFIER;
  wire dma_cyc = I_ADDRESS_ENABLE_QUALIFIER && I_DMA_ACK;
  wire hit_data = cpu_cyc && (ofs == OFS_DATA) && (mode == MODE_STD || mode == MODE_BYTE);
  wire hit_afifo = cpu_cyc && (ofs == OFS_DATA) && is_ecp;
  wire hit_status = cpu_cyc && (ofs == OFS_STATUS);
  wire hit_ctrl = cpu_cyc && (ofs == OFS_CONTROL);
  // reserved and unlisted modes fall through unmapped
  wire fifo_mode = (mode == MODE_COMPAT_FIFO) || is_ecp || (mode == MODE_TEST);
  wire hit_fifo = (cpu_cyc && (ofs == OFS_FIFO) && fifo_mode) || (dma_cyc && fifo_mode);
  wire hit_cfga = cpu_cyc && (ofs == OFS_FIFO) && (mode == MODE_CONFIG);
  wire hit_cfgb = cpu_cyc && (ofs == OFS_CFGB) && (mode == MODE_CONFIG);
  wire hit_ecr = cpu_cyc && (ofs == OFS_ECR);

  // fifo write allowed in forward modes and test; reads in reverse and test
  wire fifo_wr_ok = (mode == MODE_COMPAT_FIFO) || (is_ecp && !dir) || (mode == MODE_TEST);
  wire fifo_rd_ok = rev_mode || (mode == MODE_TEST);
  wire bus_push = I_WR_STB && ((hit_fifo && fifo_wr_ok) || (hit_afifo && !dir));
  wire bus_pop = I_RD_STB && hit_fifo && fifo_rd_ok;
  wire [7:0] fifo_rd_val = fifo_bus.empty ? last_q : fifo_bus.rdata[7:0];
  wire [7:0] status_val = {~busy_s, nack_s, perror_s, select_s, nfault_s, 3'h0};
  wire ecr_wr = I_WR_STB && hit_ecr;
  wire [2:0] new_mode = I_WDATA[7:5];
  // leaving fifo modes through a plain port mode discards queued bytes
  wire flush = ecr_wr && (new_mode == MODE_STD || new_mode == MODE_BYTE);

  logic [7:0] rd_val;
  logic rd_hit;

  always_comb
  begin
    rd_hit = 1'b1;
    if (hit_status)
      rd_val = status_val;
    else if (hit_ctrl)
      rd_val = {2'h0, dcr_q};
    else if (hit_ecr)
      rd_val = {ecr_q, fifo_bus.full, fifo_bus.empty};
    else if (hit_data)
      rd_val = O_PD_OE ? data_q : pd_s;
    else if (hit_cfga)
      rd_val = CFGA_VALUE;
    else if (hit_cfgb)
      rd_val = {1'b0, ~nfault_s, I_CFG_RESOURCES};
    else if (hit_fifo && fifo_rd_ok)
      rd_val = fifo_rd_val;
    else
    begin
      rd_val = 8'h00;
      rd_hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // link engine
  // ----------------------------------------------------------------
  // periphack high means data, low means command
  wire rev_is_data = busy_s;
  wire rle_cmd = !busy_s && !pd_s[RLE_ADDR_BIT];
  logic eng_pop;
  logic eng_push;
  logic rev_cap;

  always_comb
  begin
    st_d = st_q;
    eng_pop = 1'b0;
    eng_push = 1'b0;
    rev_cap = 1'b0;
    case (st_q)
      LS_IDLE:
        // start on busy low, bus permitted
        if (fwd_mode && !fifo_bus.empty && !busy_s && (perror_s || !is_ecp))
        begin
          st_d = LS_FWD_SETUP;
          eng_pop = 1'b1;
        end
        else if (rev_mode && !perror_s && !fifo_bus.full)
          st_d = LS_REV_REQ;
      LS_FWD_SETUP:
        st_d = LS_FWD_STROBE;
      LS_FWD_STROBE:
        if (busy_s)
          st_d = LS_FWD_RELEASE;
      LS_FWD_RELEASE:
        if (!busy_s)
          st_d = LS_IDLE;
      LS_REV_REQ:
        if (!nack_s)
        begin
          rev_cap = 1'b1;
          st_d = LS_REV_DONE;
          eng_push = rev_is_data && !rle_pend_q;
        end
      LS_REV_DONE:
        if (nack_s)
          st_d = (rep_q != 8'h00) ? LS_REV_EXPAND : LS_IDLE;
      LS_REV_EXPAND:
        if (!fifo_bus.full)
        begin
          eng_push = 1'b1;
          if (rep_q == 8'h01)
            st_d = LS_IDLE;
        end
      default:
        st_d = LS_IDLE;
    endcase
    if (st_q[2] ? !rev_mode : (st_q != LS_IDLE && !fwd_mode)) // reverse states carry bit 2
      st_d = LS_IDLE;
  end

  assign fifo_bus.push = eng_push || bus_push;
  assign fifo_bus.pop = eng_pop || bus_pop;
  assign fifo_bus.flush = flush;
  assign fifo_bus.wdata = (st_q == LS_REV_EXPAND) ? {1'b0, rep_data_q} :
                          eng_push ? {1'b0, pd_s} : {hit_afifo, I_WDATA};

  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      st_q <= LS_IDLE;
    else if (I_CLK_EN)
      st_q <= st_d;
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      link_data_q <= 8'h00;
      link_tag_q <= 1'b0;
      rle_pend_q <= 1'b0;
      rle_cnt_q <= 7'h00;
      rep_q <= 8'h00;
      rep_data_q <= 8'h00;
    end
    else if (I_CLK_EN)
    begin
      if (eng_pop)
      begin
        link_data_q <= fifo_bus.rdata[7:0];
        link_tag_q <= fifo_bus.rdata[8];
      end
      if (rev_cap && rle_cmd)
      begin
        rle_pend_q <= 1'b1;
        rle_cnt_q <= pd_s[6:0];
      end
      else if (rev_cap && rev_is_data && rle_pend_q)
      begin
        rle_pend_q <= 1'b0;
        rep_q <= {1'b0, rle_cnt_q} + 8'h01;
        rep_data_q <= pd_s;
      end
      else if (st_q == LS_REV_EXPAND && eng_push)
        rep_q <= rep_q - 8'h01;
      if (st_d == LS_IDLE && st_q != LS_IDLE)
        rep_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      data_q <= DATA_RESET;
      dcr_q <= DCR_RESET;
      ecr_q <= ECR_RESET;
      last_q <= 8'h00;
      nfault_prev_q <= 1'b1;
    end
    else if (I_CLK_EN)
    begin
      if (I_WR_STB && hit_data)
        data_q <= I_WDATA;
      if (I_WR_STB && hit_ctrl)
        dcr_q <= I_WDATA[5:0];
      if (ecr_wr)
        ecr_q <= I_WDATA[7:2];
      if (bus_pop && !fifo_bus.empty)
        last_q <= fifo_bus.rdata[7:0];
      nfault_prev_q <= nfault_s;
    end
  end

  // ----------------------------------------------------------------
  // pin and bus outputs
  // ----------------------------------------------------------------
  // in ecp drive only with forward acknowledged; std and compat fifo always drive, other modes drive while dir is low
  wire pd_oe_d = (mode == MODE_STD || mode == MODE_COMPAT_FIFO) ? 1'b1 :
                 is_ecp ? (!dir && perror_s) : !dir;
  wire [7:0] pd_out_d = fwd_mode ? link_data_q :
                        (mode == MODE_TEST) ? fifo_rd_val : data_q;
  wire eng_pins = (mode == MODE_COMPAT_FIFO) || is_ecp;
  wire nstrobe_d = eng_pins ? (st_q != LS_FWD_STROBE) : ~dcr_q[DCR_STROBE];
  wire fwd_busy_st = (st_q == LS_FWD_SETUP) || (st_q == LS_FWD_STROBE) || (st_q == LS_FWD_RELEASE);
  wire nautofd_d = !is_ecp ? ~dcr_q[DCR_AUTOFD] :
                   fwd_busy_st ? ~link_tag_q : (st_q != LS_REV_REQ);
  wire ninit_d = is_ecp ? ~dir : dcr_q[DCR_NINIT];
  wire nselin_d = is_ecp ? 1'b1 : ~dcr_q[DCR_SELIN];
  wire dma_d = ecr_q[ECR_DMAEN] && !ecr_q[ECR_SVC] &&
               ((fwd_mode && !fifo_bus.full) || (rev_mode && !fifo_bus.empty));
  // fault edge or unmask while low
  wire irq_d = is_ecp && !nfault_s &&
               ((nfault_prev_q && !ecr_q[ECR_NERRINT]) || (ecr_wr && ecr_q[ECR_NERRINT] && !I_WDATA[4]));

  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_RDATA <= 8'h00;
      O_RDATA_VLD <= 1'b0;
      O_DMA_REQ <= 1'b0;
      O_FAULT_IRQ <= 1'b0;
      O_PD_OUT <= 8'h00;
      O_PD_OE <= 1'b1;
      O_NSTROBE <= 1'b1;
      O_NAUTOFD <= 1'b1;
      O_NINIT <= 1'b0;
      O_NSELECTIN <= 1'b1;
    end
    else if (I_CLK_EN)
    begin
      O_RDATA_VLD <= I_RD_STB && rd_hit;
      if (I_RD_STB && rd_hit)
        O_RDATA <= rd_val;
      O_DMA_REQ <= dma_d;
      O_FAULT_IRQ <= irq_d;
      O_PD_OUT <= pd_out_d;
      O_PD_OE <= pd_oe_d;
      O_NSTROBE <= nstrobe_d;
      O_NAUTOFD <= nautofd_d;
      O_NINIT <= ninit_d;
      O_NSELECTIN <= nselin_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N || !I_CLK_EN);

  AST_FWD_STROBE_SEQ: assert property ((st_q == LS_FWD_SETUP && eng_pins)
    |=> (st_q == LS_FWD_STROBE || !eng_pins) ##1 (!O_NSTROBE || !$past(eng_pins))) else $error("strobe not issued");
  AST_FWD_WAIT_BUSY: assert property ((st_q == LS_FWD_RELEASE && busy_s && fwd_mode)
    |=> st_q == LS_FWD_RELEASE) else $error("left release while busy");
  AST_HS_BUSY_ACK: assert property ((st_q == LS_FWD_STROBE && busy_s && fwd_mode)
    |=> st_q == LS_FWD_RELEASE) else $error("busy did not end strobe");
  AST_NSELECTIN_ECP: assert property (is_ecp |=> O_NSELECTIN) else $error("nselectin asserted in ecp");
  AST_NO_CONTENTION: assert property ((O_PD_OE && $past(is_ecp))
    |-> $past(perror_s) && !$past(dir)) else $error("data driven without permission");
  AST_REV_HOSTACK: assert property ((st_q == LS_REV_REQ && rev_mode) |=> !O_NAUTOFD)
    else $error("hostack not asserted");
  AST_REV_CAPTURE: assert property ((st_q == LS_REV_REQ && !nack_s && rev_mode)
    |=> st_q == LS_REV_DONE) else $error("reverse byte not taken");
  AST_RLE_NO_PUSH: assert property ((rev_cap && rle_cmd) |-> !fifo_bus.push ##1 rle_pend_q)
    else $error("rle byte passed on");
  AST_NINIT_DIR: assert property (is_ecp |=> O_NINIT == !$past(dir)) else $error("ninit wrong");
  AST_ECR_MODE: assert property (ecr_wr |=> mode == $past(I_WDATA[7:5]))
    else $error("mode field not written");
  AST_CFGA_READ: assert property ((I_RD_STB && hit_cfga)
    |=> O_RDATA_VLD && O_RDATA == CFGA_VALUE) else $error("config a wrong");
  AST_AEN_BLOCK: assert property ((I_RD_STB && I_ADDRESS_ENABLE_QUALIFIER && !I_DMA_ACK)
    |=> !O_RDATA_VLD) else $error("decode without enable");
  AST_STATUS_SELECT: assert property ((I_RD_STB && hit_status)
    |=> O_RDATA[4] == $past(select_s)) else $error("select not reported");
  AST_DMA_GATE: assert property (O_DMA_REQ |-> $past(ecr_q[ECR_DMAEN])) else $error("dma without enable");
  AST_FAULT_MODE: assert property (O_FAULT_IRQ |-> $past(is_ecp) && $past(!nfault_s))
    else $error("fault irq outside ecp");

  COV_FWD_BYTE: cover property (st_q == LS_FWD_STROBE ##[1:20] st_q == LS_IDLE);
  COV_REV_BYTE: cover property (st_q == LS_REV_REQ ##[1:20] st_q == LS_REV_DONE);
  COV_RLE_EXPAND: cover property (st_q == LS_REV_EXPAND ##[1:200] st_q == LS_IDLE);
  COV_FIFO_FULL: cover property (fifo_bus.full);

endmodule : epl_parallel_port

/* testbench/epl_periph_model.sv */
// peripheral model on the port pins, forward and reverse
// assumes tb loads tx_q {busy mark, byte}; released lines show ~last byte
module epl_periph_model
(
  input wire logic i_clk,
  input wire logic i_nstrobe,
  input wire logic i_nautofd,
  input wire logic i_ninit,
  input wire logic [7:0] i_pd_out,
  input wire logic i_pd_oe,
  output logic [7:0] o_pd_in,
  output logic o_nack,
  output logic o_busy,
  output logic o_perror
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] tx_q[$];
  logic [8:0] rx_q[$];
  logic [7:0] pd_q = 8'h00;
  logic drv = 1'b0;
  int st = 0;
  initial
  begin
    o_nack = 1'b1;
    o_busy = 1'b0;
    o_perror = 1'b1;
  end
  assign o_pd_in = i_pd_oe ? i_pd_out : (drv ? pd_q : ~pd_q);
  always @(posedge i_clk)
  begin
    o_perror <= i_ninit;
    if (i_ninit)
    begin
      if (!i_nstrobe && !o_busy)
      begin
        rx_q.push_back({i_nautofd, o_pd_in});
        o_busy <= 1'b1;
      end
      else if (i_nstrobe)
        o_busy <= 1'b0;
    end
    else if (!o_perror)
      case (st)
        0:
          if (!i_nautofd && tx_q.size() > 0)
          begin
            {o_busy, pd_q} <= tx_q[0];
            drv <= 1'b1;
            st <= 1;
          end
        1:
        begin
          o_nack <= 1'b0;
          st <= 2;
        end
        default:
          if (i_nautofd)
          begin
            o_nack <= 1'b1;
            drv <= 1'b0;
            void'(tx_q.pop_front());
            st <= 0;
          end
      endcase
  end
endmodule : epl_periph_model

/* testbench/ecp_parallel_port_link_tb.sv */
// self-checking bench for the ecp parallel port
// assumes the peripheral model on the pins, 100 MHz clock
module ecp_parallel_port_link_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] BASE = 16'h0278;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic address_enable_qualifier = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic sel = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00;
  logic nflt = 1'b1;
  logic dack = 1'b0;
  logic [7:0] rdata, pdo, pdi;
  logic vld, dreq, irq, oe, nstb, nafd, ninit, nsel, nack, busy, perr;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int irq_cnt = 0;
  always #5 clk = ~clk;
  epl_parallel_port i_dut (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_CLK_EN(1'b1),
    .I_BASE_ADDR(BASE), .I_ADDR(addr), .I_ADDRESS_ENABLE_QUALIFIER(address_enable_qualifier),
    .I_RD_STB(rd), .I_WR_STB(wr), .I_WDATA(wd), .I_DMA_ACK(dack),
    .I_CFG_RESOURCES(6'h2A), .I_PD_IN(pdi), .I_NACK(nack), .I_BUSY(busy),
    .I_PERROR(perr), .I_SELECT(sel), .I_NFAULT(nflt), .O_RDATA(rdata),
    .O_RDATA_VLD(vld), .O_DMA_REQ(dreq), .O_FAULT_IRQ(irq), .O_PD_OUT(pdo),
    .O_PD_OE(oe), .O_NSTROBE(nstb), .O_NAUTOFD(nafd), .O_NINIT(ninit),
    .O_NSELECTIN(nsel));
  epl_periph_model i_per (.i_clk(clk), .i_nstrobe(nstb), .i_nautofd(nafd),
    .i_ninit(ninit), .i_pd_out(pdo), .i_pd_oe(oe), .o_pd_in(pdi),
    .o_nack(nack), .o_busy(busy), .o_perror(perr));

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic [15:0] ofs, input logic w, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = BASE + ofs;
    wd = d;
    wr = w;
    rd = !w;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask : bus

  task automatic rd_reg(input logic [15:0] ofs, input logic v, input logic [7:0] exp);
    bus(ofs, 1'b0, 8'h00);
    chk({8'h00, vld}, {8'h00, v});
    if (v)
      chk({1'b0, rdata}, {1'b0, exp});
  endtask : rd_reg

  task automatic wait_rx(input int n);
    for (int i = 0; i < 400 && i_per.rx_q.size() < n; i++)
      @(posedge clk);
  endtask : wait_rx

  task automatic t_regs();
    rd_reg(16'h0001, 1'b1, 8'hD8);
    sel = 1'b0;
    repeat (8) @(posedge clk);
    rd_reg(16'h0001, 1'b1, 8'hC8);
    bus(16'h0402, 1'b1, 8'hE0);
    rd_reg(16'h0400, 1'b1, 8'h10);
    rd_reg(16'h0401, 1'b1, 8'h2A);
    rd_reg(16'h0402, 1'b1, 8'hE1);
    rd_reg(16'h0003, 1'b0, 8'h00);
    address_enable_qualifier = 1'b1;
    rd_reg(16'h0402, 1'b0, 8'h00);
    address_enable_qualifier = 1'b0;
    bus(16'h0402, 1'b1, 8'hA0);
    rd_reg(16'h0400, 1'b0, 8'h00);
    bus(16'h0402, 1'b1, 8'h20);
    bus(16'h0000, 1'b1, 8'h5A);
    rd_reg(16'h0000, 1'b1, 8'h5A);
  endtask : t_regs

  task automatic t_fwd();
    bus(16'h0002, 1'b1, 8'h04);
    bus(16'h0402, 1'b1, 8'h40);
    bus(16'h0400, 1'b1, 8'h11);
    bus(16'h0400, 1'b1, 8'h22);
    wait_rx(2);
    chk({1'b0, i_per.rx_q[0][7:0]}, 9'h011);
    chk({1'b0, i_per.rx_q[1][7:0]}, 9'h022);
    i_per.rx_q.delete();
    bus(16'h0402, 1'b1, 8'h60);
    bus(16'h0000, 1'b1, 8'h07);
    bus(16'h0400, 1'b1, 8'h33);
    wait_rx(2);
    chk(i_per.rx_q[0], 9'h007);
    chk(i_per.rx_q[1], 9'h133);
    chk({8'h00, nsel}, 9'h001);
  endtask : t_fwd

  task automatic t_rev();
    // count 2 then data: three copies; channel address dropped
    i_per.tx_q = '{9'h002, 9'h1AA, 9'h081};
    bus(16'h0002, 1'b1, 8'h20);
    for (int i = 0; i < 400 && i_per.tx_q.size() > 0; i++)
      @(posedge clk);
    repeat (8) @(posedge clk);
    chk({8'h00, oe}, 9'h000);
    chk({8'h00, ninit}, 9'h000);
    for (int i = 0; i < 3; i++)
      rd_reg(16'h0400, 1'b1, 8'hAA);
    rd_reg(16'h0402, 1'b1, 8'h61);
  endtask : t_rev

  task automatic t_dma_irq();
    i_per.rx_q.delete();
    bus(16'h0402, 1'b1, 8'h68);
    bus(16'h0002, 1'b1, 8'h04);
    repeat (2) @(posedge clk);
    #1;
    chk({8'h00, dreq}, 9'h001);
    address_enable_qualifier = 1'b1;
    dack = 1'b1;
    bus(16'h0000, 1'b1, 8'h44);
    address_enable_qualifier = 1'b0;
    dack = 1'b0;
    wait_rx(1);
    chk(i_per.rx_q[0], 9'h144);
    bus(16'h0402, 1'b1, 8'h64);
    repeat (2) @(posedge clk);
    #1;
    chk({8'h00, dreq}, 9'h000);
    // fault edge gives one pulse, unmasking while low a second
    nflt = 1'b0;
    repeat (10) @(posedge clk);
    bus(16'h0402, 1'b1, 8'h74);
    bus(16'h0402, 1'b1, 8'h64);
    repeat (2) @(posedge clk);
    #1;
    chk(9'(irq_cnt), 9'h002);
    nflt = 1'b1;
    bus(16'h0402, 1'b1, 8'hC4);
    bus(16'h0400, 1'b1, 8'h3C);
    rd_reg(16'h0400, 1'b1, 8'h3C);
    rd_reg(16'h0400, 1'b1, 8'h3C);
  endtask : t_dma_irq

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1'b1;
    // let the pin synchronisers fill before the first status read
    repeat (8) @(posedge clk);
    t_regs();
    t_fwd();
    t_rev();
    t_dma_irq();
    complete_run();
  end

  // ceiling well above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (irq)
      irq_cnt++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
endmodule : ecp_parallel_port_link_tb
